// ===== hdl/usart_frame_transmitter.sv
// Serial frame transmitter with transmit FIFO and first-stop receive check
`timescale 1ns/1ps
`default_nettype none
`include "usart_tx_consts.svh"

module tx_word_fifo #(
   parameter int WIDTH = `TX_WORD_WIDTH,
   parameter int DEPTH = `TX_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   wire              push = inValid && inReady;
   wire              pop  = outValid && outReady;
   // Ready is registered from the next count, so a full FIFO shows at once
   wire [AW:0]       nextCount = count + (AW+1)'(push) - (AW+1)'(pop);

   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         inReady <= 1'b0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         count   <= nextCount;
         inReady <= (nextCount != (AW+1)'(DEPTH));
      end
   end
endmodule // tx_word_fifo

module usart_frame_transmitter #(
   parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        dataWrite,
   input  wire logic [7:0]                  dataIn,
   output logic                             dataReady,
   input  wire logic                        txNinthBit,
   input  wire logic [2:0]                  charSizeSel,
   input  wire logic [1:0]                  parityModeSel,
   input  wire logic                        stopBitsSel,
   input  wire logic                        txEnableBit,
   input  wire logic                        rxEnableBit,
   input  wire logic                        syncMode,
   input  wire logic                        doubleSpeedBit,
   input  wire logic [`BAUD_DIV_WIDTH-1:0]  baudDivisor,
   input  wire logic                        txCompleteClear,
   input  wire logic                        rxRead,
   input  wire logic                        transferClockPin,
   input  wire logic                        rxPin,
   output logic                             txPin,
   output logic                             txPinOe,
   output logic                             transferClockTaken,
   output logic                             txBufferEmptyFlag,
   output logic                             txCompleteFlag,
   output logic                             rxCompleteFlag,
   output logic                             frameErrorFlag,
   output logic [8:0]                       rxData
);
   import usart_tx_pkg::*;

   // Pin synchronisers: a new level counts once stages 2 and 3 agree
   logic [2:0] xckSync;
   logic [2:0] rxSync;
   logic       xckLevel;
   logic       xckPrev;
   logic       rxLevel;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xckSync  <= 3'h0;
         rxSync   <= 3'h7;
         xckLevel <= 1'b0;
         xckPrev  <= 1'b0;
         rxLevel  <= 1'b1;
      end else begin
         xckSync <= {xckSync[1:0], transferClockPin};
         rxSync  <= {rxSync[1:0], rxPin};
         if (xckSync[1] == xckSync[2]) begin
            xckLevel <= xckSync[2];
         end
         if (rxSync[1] == rxSync[2]) begin
            rxLevel <= rxSync[2];
         end
         xckPrev <= xckLevel;
      end
   end

   // Shared format decode for both directions [RL5] [RL9]
   wire        nineBits  = (charSizeSel == `CHAR_SIZE_NINE);
   wire [3:0]  nBits     = nineBits ? 4'h9 :
                           (charSizeSel > `CHAR_SIZE_EIGHT) ? 4'h8 :
                           4'h5 + {2'h0, charSizeSel[1:0]};
   wire        parityOn  = parityModeSel[1];
   wire        parityOdd = (parityModeSel == `PARITY_ODD);
   wire [3:0]  phaseLast = doubleSpeedBit ? `PHASE_LAST_DBL
                                          : `PHASE_LAST_NORM;

   // Baud divider; the transmitter ticks once per phase wrap [RL14]
   logic [`BAUD_DIV_WIDTH-1:0] baudCount;
   logic [3:0]                 txPhase;
   wire  baudZero  = (baudCount == '0);
   wire  asyncTick = baudZero && (txPhase == phaseLast);
   wire  xckRise   = xckLevel && !xckPrev;
   wire  bitTick   = syncMode ? xckRise : asyncTick;   // [RL11] [RL14]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baudCount <= '0;
         txPhase   <= 4'h0;
      end else begin
         baudCount <= baudZero ? baudDivisor : baudCount - 1'b1;
         if (baudZero) begin
            txPhase <= (txPhase >= phaseLast) ? 4'h0 : txPhase + 4'h1;
         end
      end
   end

   // Transmit buffer; the ninth bit is caught with the write [RL12]
   logic       fifoValid;
   logic [8:0] fifoData;
   logic       fifoPop;
   logic       fifoReady;

   tx_word_fifo #(
      .WIDTH (`TX_WORD_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (dataWrite),
      .inData   ({txNinthBit, dataIn}),
      .inReady  (fifoReady),
      .outValid (fifoValid),
      .outData  (fifoData),
      .outReady (fifoPop)
   );
   // Taken straight from the FIFO's ready flop; a second flop would lag
   assign dataReady = fifoReady;

   // Transmit shifter
   tx_state_t  txState;
   tx_state_t  next_txState;
   logic [8:0] txShift;
   logic [3:0] bitIndex;
   logic       txParity;
   logic       txActive;

   // Upper bits beyond the character size are dropped here [RL15]
   wire [8:0]  sizeMask   = 9'h1FF >> (4'h9 - nBits);
   wire [8:0]  loadWord   = fifoData & sizeMask;
   wire        loadParity = (^loadWord) ^ parityOdd;           // [RL8]
   wire        lastData   = (bitIndex == nBits - 4'h1);
   wire        stopEnd    = bitTick && ((txState == TX_STOP2) ||
                            (txState == TX_STOP1 && !stopBitsSel));
   wire        loadSlot   = bitTick && (txState == TX_IDLE || stopEnd);
   assign fifoPop = loadSlot && fifoValid && txActive;         // [RL13]
   wire        frameDone  = stopEnd && !fifoValid;

   always_comb begin
      next_txState = txState;
      if (bitTick) begin
         unique case (txState)
            TX_IDLE:   next_txState = fifoPop ? TX_START : TX_IDLE;
            TX_START:  next_txState = TX_DATA;
            TX_DATA:   next_txState = !lastData ? TX_DATA :
                                      parityOn ? TX_PARITY : TX_STOP1; // [RL3]
            TX_PARITY: next_txState = TX_STOP1;
            TX_STOP1:  next_txState = stopBitsSel ? TX_STOP2 :
                                      fifoPop ? TX_START : TX_IDLE;  // [RL4]
            TX_STOP2:  next_txState = fifoPop ? TX_START : TX_IDLE;  // [RL4]
            default:   next_txState = TX_IDLE;
         endcase
      end
   end

   // Start low, data LSB first, parity, stops and idle high [RL24] [RL2]
   wire next_txPin = (txState == TX_START)  ? 1'b0 :
                     (txState == TX_DATA)   ? txShift[0] :
                     (txState == TX_PARITY) ? txParity : 1'b1;

   // Enable release waits for buffer and shifter to drain [RL23]
   wire drained     = (txState == TX_IDLE) && !fifoValid;
   wire next_active = txEnableBit || (txActive && !drained);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txState  <= TX_IDLE;
         txShift  <= 9'h000;
         bitIndex <= 4'h0;
         txParity <= 1'b0;
         txActive <= 1'b0;
      end else begin
         txState  <= next_txState;
         txActive <= next_active;
         if (fifoPop) begin
            txShift  <= loadWord;
            txParity <= loadParity;
            bitIndex <= 4'h0;
         end else if (bitTick && txState == TX_DATA) begin
            txShift  <= {1'b0, txShift[8:1]};                  // [RL2]
            bitIndex <= bitIndex + 4'h1;
         end
      end
   end

   // Registered pin, pin takeover and flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txPin              <= 1'b1;
         txPinOe            <= 1'b0;
         transferClockTaken <= 1'b0;
         txBufferEmptyFlag  <= 1'b1;
         txCompleteFlag     <= 1'b0;
      end else begin
         txPin              <= next_txPin;                     // [RL24]
         txPinOe            <= next_active;                    // [RL10]
         transferClockTaken <= next_active && syncMode;        // [RL11]
         // Empty means nothing left waiting for the shifter [RL21]
         txBufferEmptyFlag  <= !fifoValid && !dataWrite;
         // A completing frame wins over a same-cycle clear [RL22]
         if (frameDone) begin
            txCompleteFlag <= 1'b1;                            // [RL20]
         end else if (txCompleteClear) begin
            txCompleteFlag <= 1'b0;
         end
      end
   end

   // Receive check: samples mid-bit, looks at the first stop bit only
   rx_state_t  rxState;
   logic [3:0] rxPhase;
   logic [3:0] rxIndex;
   logic [8:0] rxShift;
   wire        rxMid    = baudZero && (rxPhase == (phaseLast >> 1));
   wire        rxLast   = (rxIndex == nBits - 4'h1);
   wire        rxStopHit = rxMid && (rxState == RX_STOP);
   wire [8:0]  rxAligned = rxShift >> (4'h9 - nBits);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxState        <= RX_IDLE;
         rxPhase        <= 4'h0;
         rxIndex        <= 4'h0;
         rxShift        <= 9'h000;
         rxData         <= 9'h000;
         rxCompleteFlag <= 1'b0;
         frameErrorFlag <= 1'b0;
      end else begin
         if (baudZero) begin
            rxPhase <= (rxPhase >= phaseLast) ? 4'h0 : rxPhase + 4'h1;
         end
         if (!rxEnableBit) begin
            rxState <= RX_IDLE;
         end else if (rxState == RX_IDLE) begin
            if (!rxLevel) begin
               rxState <= RX_START;
               rxPhase <= 4'h0;
            end
         end else if (rxMid) begin
            unique case (rxState)
               RX_START: begin
                  rxState <= rxLevel ? RX_IDLE : RX_DATA;
                  rxIndex <= 4'h0;
               end
               RX_DATA: begin
                  rxShift <= {rxLevel, rxShift[8:1]};
                  rxIndex <= rxIndex + 4'h1;
                  if (rxLast) begin
                     rxState <= parityOn ? RX_PARITY : RX_STOP;
                  end
               end
               RX_PARITY: rxState <= RX_STOP;
               RX_STOP:   rxState <= RX_IDLE;  // Second stop is ignored
               default:   rxState <= RX_IDLE;
            endcase
         end
         if (rxStopHit) begin
            rxData         <= rxAligned;
            frameErrorFlag <= !rxLevel;                        // [RL7]
         end
         // New data wins over a same-cycle read; disable flushes [RL20]
         if (!rxEnableBit) begin
            rxCompleteFlag <= 1'b0;
         end else if (rxStopHit) begin
            rxCompleteFlag <= 1'b1;
         end else if (rxRead) begin
            rxCompleteFlag <= 1'b0;
         end
      end
   end

   // Checks
   chk_start_low: assert property (@(posedge clk) disable iff (!rst_n)
      txState == TX_START |=> !txPin)                          // [RL24]
      else $error("start bit not low");
   chk_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
      (txState == TX_STOP1 || txState == TX_STOP2 || txState == TX_IDLE)
      |=> txPin)                                               // [RL4]
      else $error("stop or idle not high");
   chk_parity_bit: assert property (@(posedge clk) disable iff (!rst_n)
      txState == TX_PARITY |=> txPin == $past(txParity))       // [RL8]
      else $error("parity bit wrong");
   chk_parity_place: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(txState) && txState == TX_PARITY
      |-> $past(txState) == TX_DATA && parityOn)               // [RL3]
      else $error("parity out of place");
   chk_data_count: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(txState == TX_DATA) |-> $past(bitIndex) == nBits - 4'h1) // [RL1]
      else $error("wrong data bit count");
   chk_load_slot: assert property (@(posedge clk) disable iff (!rst_n)
      fifoPop |-> txState inside {TX_IDLE, TX_STOP1, TX_STOP2}) // [RL13]
      else $error("shifter loaded mid frame");
   chk_empty_clear: assert property (@(posedge clk) disable iff (!rst_n)
      dataWrite && dataReady |=> !txBufferEmptyFlag)           // [RL21]
      else $error("empty flag not cleared by write");
   chk_tc_set: assert property (@(posedge clk) disable iff (!rst_n)
      frameDone |=> txCompleteFlag)                            // [RL22]
      else $error("transmit complete not set");
   chk_pin_hold: assert property (@(posedge clk) disable iff (!rst_n)
      txState != TX_IDLE |=> txPinOe)                          // [RL23]
      else $error("pin released during frame");
   chk_enable_take: assert property (@(posedge clk) disable iff (!rst_n)
      txEnableBit |=> txPinOe)                                 // [RL10]
      else $error("pin not taken while enabled");
   chk_first_stop: assert property (@(posedge clk) disable iff (!rst_n)
      rxStopHit |=> frameErrorFlag == !$past(rxLevel))         // [RL7]
      else $error("frame error not from first stop");

   cov_nine_bit: cover property (@(posedge clk) disable iff (!rst_n)
      fifoPop && nineBits && parityOn);
   cov_two_stops: cover property (@(posedge clk) disable iff (!rst_n)
      stopEnd && txState == TX_STOP2);
   cov_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
      stopEnd && fifoPop);
   cov_frame_error: cover property (@(posedge clk) disable iff (!rst_n)
      rxStopHit && !rxLevel);
endmodule // usart_frame_transmitter
`default_nettype wire

// ===== common/usart_tx_consts.svh
// Constants for the serial frame transmitter and its receive check
// Behaviour
// [RL1] Frame: start bit, 5..9 data bits, none/even/odd parity, 1 or 2 stops.
// [RL2] Data bits go out least significant first, most significant last.
// [RL3] Parity bit sits after the last data bit, before the first stop.
// [RL4] After stop bits the next start follows at once or line idles high.
// [RL5] Receiver and transmitter share one size, parity and stop setting.
// [RL6] Software keeps format settings steady while frames are in flight.
// [RL7] Receiver checks only the first stop bit; frame error when it is zero.
// [RL8] Even parity is xor of data bits; odd parity is its inverse.
// [RL9] Size field 3 bits (7 means nine), parity field 2 bits, stop 1 bit.
// [RL10] With transmit enabled the block takes and drives the transmit pin.
// [RL11] Sync mode with transmit enabled clocks bits by the transfer pin.
// [RL12] A data register write loads the transmit buffer and starts sending.
// [RL13] Buffered word enters the shifter when idle or right after last stop.
// [RL14] Shifter sends a whole frame at baud rate or transfer clock rate.
// [RL15] Unused upper bits of short characters are discarded.
// [RL16] Software sets the ninth bit before writing the low eight bits.
// [RL17] Software waits for buffer empty before writing new data.
// [RL18] Software sets baud, format and enables before communication.
// [RL19] No transfer may run while reformatting; clear complete before writes.
// [RL20] Provide transmit complete and receive complete flags.
// [RL21] Buffer empty flag is set when buffer is empty, cleared by a write.
// [RL22] Transmit complete sets when frame done and buffer empty; ack clears.
// [RL23] Disabling transmit waits for pending frames, then releases the pin.
// [RL24] Start bit is driven low, stop bits high, matching idle high.
`ifndef USART_TX_CONSTS_SVH
`define USART_TX_CONSTS_SVH

`define TX_FIFO_DEPTH    32
`define TX_WORD_WIDTH    9
`define CHAR_SIZE_NINE   3'h7
`define CHAR_SIZE_EIGHT  3'h3
`define PARITY_EVEN      2'h2
`define PARITY_ODD       2'h3
`define PHASE_LAST_NORM  4'hF
`define PHASE_LAST_DBL   4'h7
`define BAUD_DIV_WIDTH   12

`endif

// ===== common/usart_tx_pkg.sv
// Types shared by the serial frame transmitter
package usart_tx_pkg;
   typedef enum logic [2:0] {
      TX_IDLE   = 3'b000,
      TX_START  = 3'b001,
      TX_DATA   = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP1  = 3'b100,
      TX_STOP2  = 3'b101
   } tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE   = 3'b000,
      RX_START  = 3'b001,
      RX_DATA   = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP   = 3'b100
   } rx_state_t;
endpackage

// ===== test/serial_peer_model.sv
// Remote serial peer: decodes frames on the transmit line, sends frames
`timescale 1ns/1ps
`default_nettype none

module serial_peer_model (
   input  wire logic        clk,
   input  wire logic        txPin,
   input  wire logic        txPinOe,
   input  wire logic [3:0]  nBits,
   input  wire logic        parityOn,
   input  wire logic        twoStop,
   input  wire logic [15:0] bitClocks,
   output logic             rxPin
);
   logic [8:0] gotData[$];
   logic       gotPar[$];
   logic [1:0] gotStop[$];
   int         gotStart[$];
   int         cycle = 0;
   logic [8:0] d;
   logic       p;
   logic [1:0] s;

   initial rxPin = 1'b1;
   always @(posedge clk) cycle <= cycle + 1;

   task automatic bit_time();
      repeat (bitClocks) @(posedge clk);
   endtask

   // Each bit is sampled in its middle, counted from the start edge
   always begin
      @(posedge clk iff (txPinOe === 1'b1 && txPin === 1'b0));
      gotStart.push_back(cycle);
      {d, p, s} = {9'h000, 1'b0, 2'b11};
      repeat (bitClocks / 2) @(posedge clk);
      for (int i = 0; i < nBits; i++) begin
         bit_time();
         d[i] = txPin;
      end
      if (parityOn) begin
         bit_time();
         p = txPin;
      end
      bit_time();
      s[0] = txPin;
      if (twoStop) begin
         bit_time();
         s[1] = txPin;
      end
      gotPar.push_back(p);
      gotStop.push_back(s);
      gotData.push_back(d);
   end

   // The line returns high after a frame, as a pulled-up wire would
   task automatic send_frame(input logic [8:0] v, input logic par,
                             input logic [1:0] stops);
      rxPin <= 1'b0;
      bit_time();
      for (int i = 0; i < nBits; i++) begin
         rxPin <= v[i];
         bit_time();
      end
      if (parityOn) begin
         rxPin <= par;
         bit_time();
      end
      rxPin <= stops[0];
      bit_time();
      if (twoStop) begin
         rxPin <= stops[1];
         bit_time();
      end
      rxPin <= 1'b1;
   endtask
endmodule // serial_peer_model

`default_nettype wire

// ===== test/usart_frame_transmitter_bench.sv
// Self-checking bench for the serial frame transmitter
`timescale 1ns/1ps
`default_nettype none
`include "usart_tx_consts.svh"

`define CHECK(g, e) begin numChecks++; if ((g) !== (e)) begin \
   miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
   end end

module usart_frame_transmitter_bench;
   logic                       clk = 1'b0;
   logic                       rst_n = 1'b0;
   logic                       dataWrite = 1'b0;
   logic [7:0]                 dataIn = 8'h00;
   logic                       txNinthBit = 1'b0;
   logic [2:0]                 charSizeSel = 3'h3;
   logic [1:0]                 parityModeSel = 2'h0;
   logic                       stopBitsSel = 1'b0;
   logic                       txEnableBit = 1'b1;
   logic                       rxEnableBit = 1'b0;
   logic                       syncMode = 1'b0;
   logic                       doubleSpeedBit = 1'b0;
   logic [`BAUD_DIV_WIDTH-1:0] baudDivisor = '0;
   logic                       txCompleteClear = 1'b0;
   logic                       rxRead = 1'b0;
   logic                       transferClockPin = 1'b0;
   wire                        rxPin, dataReady, txPin, txPinOe;
   wire                        transferClockTaken, txBufferEmptyFlag;
   wire                        txCompleteFlag, rxCompleteFlag;
   wire                        frameErrorFlag;
   wire  [8:0]                 rxData, dataMask;
   wire  [3:0]                 nBits;
   wire  [15:0]                bitClocks;
   int                         miscompares = 0;
   int                         numChecks = 0;
   logic [8:0]                 expQ[$];
   int                         starts[$];

   assign nBits = (charSizeSel == 3'h7) ? 4'h9 :
                  (charSizeSel > 3'h3) ? 4'h8 : 4'(charSizeSel) + 4'h5;
   assign dataMask = 9'h1FF >> (4'h9 - nBits);
   assign bitClocks = syncMode ? 16'h0020 :
                      16'((baudDivisor + 1) << (doubleSpeedBit ? 3 : 4));

   always #50 clk = ~clk;

   usart_frame_transmitter usart_frame_transmitter_i (
      .clk(clk), .rst_n(rst_n), .dataWrite(dataWrite), .dataIn(dataIn),
      .dataReady(dataReady), .txNinthBit(txNinthBit),
      .charSizeSel(charSizeSel), .parityModeSel(parityModeSel),
      .stopBitsSel(stopBitsSel), .txEnableBit(txEnableBit),
      .rxEnableBit(rxEnableBit), .syncMode(syncMode),
      .doubleSpeedBit(doubleSpeedBit), .baudDivisor(baudDivisor),
      .txCompleteClear(txCompleteClear), .rxRead(rxRead),
      .transferClockPin(transferClockPin), .rxPin(rxPin), .txPin(txPin),
      .txPinOe(txPinOe), .transferClockTaken(transferClockTaken),
      .txBufferEmptyFlag(txBufferEmptyFlag),
      .txCompleteFlag(txCompleteFlag), .rxCompleteFlag(rxCompleteFlag),
      .frameErrorFlag(frameErrorFlag), .rxData(rxData));

   serial_peer_model peer (
      .clk(clk), .txPin(txPin), .txPinOe(txPinOe), .nBits(nBits),
      .parityOn(parityModeSel[1]), .twoStop(stopBitsSel),
      .bitClocks(bitClocks), .rxPin(rxPin));

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Only words offered while there is room are expected on the line
   task automatic burst(input int n, input logic [8:0] w);
      for (int i = 0; i < n; i++) begin
         if (dataReady === 1'b1) expQ.push_back(w + 9'(i));
         {txNinthBit, dataIn} = w + 9'(i);
         dataWrite = 1'b1;
         @(negedge clk);
      end
      dataWrite = 1'b0;
   endtask

   task automatic check_frames(input int n);
      logic [8:0] w, d;
      logic       p;
      logic [1:0] s;
      int         k;
      for (int f = 0; f < n; f++) begin
         k = 0;
         while (peer.gotData.size() == 0 && k < 4000) begin
            @(negedge clk);
            k++;
         end
         `CHECK(k < 4000, 1'b1)
         if (k == 4000) return;
         w = expQ.pop_front();
         starts.push_back(peer.gotStart.pop_front());
         d = peer.gotData.pop_front();
         p = peer.gotPar.pop_front();
         s = peer.gotStop.pop_front();
         `CHECK(d, w & dataMask)
         if (parityModeSel[1])
            `CHECK(p, ^(w & dataMask) ^ parityModeSel[0])
         `CHECK(s, 2'b11)
      end
   endtask

   task automatic clear_tx;
      txCompleteClear = 1'b1;
      @(negedge clk);
      txCompleteClear = 1'b0;
      @(negedge clk);
      `CHECK(txCompleteFlag, 1'b0)
   endtask

   task automatic wait_tx_done;
      repeat (2 * bitClocks) begin
         @(negedge clk);
         if (txCompleteFlag === 1'b1) break;
      end
      `CHECK(txCompleteFlag, 1'b1)
   endtask

   task automatic test_reset;
      repeat (10) @(negedge clk);
      `CHECK({txPin, txPinOe, txBufferEmptyFlag, dataReady}, 4'hA)
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      `CHECK(txPinOe, 1'b1)
      $display("reset test done");
   endtask

   task automatic test_formats;
      logic [2:0] sz [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
      logic [1:0] pm [3] = '{2'h0, 2'h2, 2'h3};
      for (int a = 0; a < 5; a++) begin
         for (int b = 0; b < 3; b++) begin
            for (int c = 0; c < 2; c++) begin
               // Format only changes while nothing is in flight
               {charSizeSel, parityModeSel, stopBitsSel} =
                  {sz[a], pm[b], c[0]};
               clear_tx();
               `CHECK(txBufferEmptyFlag, 1'b1)
               burst(1, 9'h1A5 ^ 9'(a * 101 + b * 37 + c * 5));
               check_frames(1);
               wait_tx_done();
            end
         end
      end
      $display("formats test done");
   endtask

   task automatic test_back_to_back;
      {charSizeSel, parityModeSel, stopBitsSel} = {3'h3, 2'h3, 1'b1};
      baudDivisor = 12'h002;
      doubleSpeedBit = 1'b1;
      starts.delete();
      clear_tx();
      burst(3, 9'h0F0);
      `CHECK(txBufferEmptyFlag, 1'b0)
      check_frames(1);
      `CHECK(txCompleteFlag, 1'b0)
      check_frames(2);
      `CHECK(starts[1] - starts[0], 12 * int'(bitClocks))
      `CHECK(starts[2] - starts[1], 12 * int'(bitClocks))
      wait_tx_done();
      $display("back-to-back test done");
   endtask

   task automatic test_fill_disable;
      int n;
      baudDivisor = '0;
      doubleSpeedBit = 1'b0;
      {charSizeSel, parityModeSel, stopBitsSel} = {3'h3, 2'h0, 1'b0};
      burst(36, 9'h040);
      n = expQ.size();
      `CHECK(dataReady, 1'b0)
      `CHECK(n < 36, 1'b1)
      txEnableBit = 1'b0;
      check_frames(n - 1);
      `CHECK(txPinOe, 1'b1)
      check_frames(1);
      repeat (bitClocks) @(negedge clk);
      `CHECK({txPinOe, txPin}, 2'b01)
      txEnableBit = 1'b1;
      $display("fill and disable test done");
   endtask

   task automatic test_sync_clock;
      syncMode = 1'b1;
      repeat (2) @(negedge clk);
      `CHECK(transferClockTaken, 1'b1)
      clear_tx();
      // The external clock runs only around the frame
      fork
         repeat (28) begin
            repeat (16) @(negedge clk);
            transferClockPin = ~transferClockPin;
         end
      join_none
      burst(1, 9'h0C3);
      check_frames(1);
      wait fork;
      wait_tx_done();
      syncMode = 1'b0;
      repeat (2) @(negedge clk);
      `CHECK(transferClockTaken, 1'b0)
      $display("sync clock test done");
   endtask

   task automatic test_rx_check;
      logic [1:0] st [2] = '{2'b11, 2'b10};
      {charSizeSel, parityModeSel, stopBitsSel} = {3'h2, 2'h2, 1'b1};
      rxEnableBit = 1'b1;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 2; i++) begin
         peer.send_frame(9'h05A, 1'b0, st[i]);
         repeat (2 * bitClocks) begin
            @(negedge clk);
            if (rxCompleteFlag === 1'b1) break;
         end
         `CHECK(rxCompleteFlag, 1'b1)
         `CHECK(rxData, 9'h05A)
         `CHECK(frameErrorFlag, ~st[i][0])
         rxRead = 1'b1;
         @(negedge clk);
         rxRead = 1'b0;
         @(negedge clk);
         `CHECK(rxCompleteFlag, 1'b0)
      end
      $display("receive check test done");
   endtask

   initial begin
      test_reset();
      test_formats();
      test_back_to_back();
      test_fill_disable();
      test_sync_clock();
      test_rx_check();
      wrap_up();
   end

   // The traffic needs some 12000 cycles; this leaves ample margin
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
endmodule // usart_frame_transmitter_bench

`default_nettype wire
